/* verilog/idp_decode_pacing.v */
// Interrupt decode and rate pacing for eight destinations
`timescale 1ns/1ps
`default_nettype none
`include "idp_defs.vh"

module idp_decode_pacing (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdData,
  // Interrupt sources, already routed elsewhere
  input  wire [31:0] condition_status_bits,
  input  wire [23:0] otherRouteSel,
  // Device reset event from any port, level
  input  wire        resetEvent,
  // Destination outputs
  output wire [7:0]  physical_irq_destination
);

  reg  [3:0]   reset_event_route_sel;
  wire [255:0] decodeFlat;
  wire [255:0] countFlat;
  wire [7:0]   armedVec;
  wire [2:0]   selIdx;
  wire [2:0]   otherSel [0:7];
  reg  [31:0]  next_rdData;

  assign selIdx = regAddr[4:2];

  // Route select register
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_event_route_sel <= `IDP_ROUTE_RST;
    end else if (regWr && regAddr == `IDP_ADDR_ROUTE) begin
      reset_event_route_sel <= regWrData[`IDP_ROUTE_MSB:0];
    end
  end

  // Per-destination decode and pacer
  genvar d;
  generate
    for (d = 0; d < `IDP_NUM_DEST; d = d + 1) begin : gDest
      wire [31:0] decode_bits;
      wire        hit;
      wire        loadDest;
      // All 32 status bits carry destination select from otherRouteSel group b%8
      assign hit = (reset_event_route_sel == d);
      genvar b;
      for (b = 0; b < `IDP_SRC_BITS; b = b + 1) begin : gBit
        if (b == `IDP_RESET_BIT) begin : gRst
          assign decode_bits[b] = (hit & resetEvent) |
                                  (condition_status_bits[b] &
                                   (otherRouteSel[3*(b%8)+:3] == d));
        end else begin : gSrc
          assign decode_bits[b] = condition_status_bits[b] &
                                  (otherRouteSel[3*(b%8)+:3] == d);
        end
      end
      assign loadDest = regWr && (regAddr[7:5] == `IDP_ADDR_PACE >> 5) &&
                        (regAddr[4:2] == d);
      assign decodeFlat[32*d+:32] = decode_bits;
      idp_pacer uPacer (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .load      (loadDest),
        .loadValue (regWrData),
        .anyStatus (|decode_bits),
        .count     (countFlat[32*d+:32]),
        .armed     (armedVec[d]),
        .irqPulse  (physical_irq_destination[d])
      );
    end
  endgenerate

  // Read mux
  always @* begin
    next_rdData = `IDP_ZERO32;
    case (regAddr[7:5])
      3'h0: if (regAddr[4:2] == 3'h0) next_rdData = {28'h0000000, reset_event_route_sel};
      3'h1: next_rdData = decodeFlat[32*selIdx+:32];
      3'h2: next_rdData = countFlat[32*selIdx+:32];
      3'h3: if (regAddr[4:2] == 3'h0) next_rdData = {24'h000000, armedVec};
      default: next_rdData = `IDP_ZERO32;
    endcase
  end

  // Read data one cycle after strobe
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= `IDP_ZERO32;
    end else if (regRd) begin
      regRdData <= next_rdData;
    end else begin
      regRdData <= `IDP_ZERO32;
    end
  end

endmodule // idp_decode_pacing

`default_nettype wire

/* verilog/idp_defs.vh */
// Constants for the interrupt decode and pacing block
// Summary of operation
// - The reset event routing register holds a 4-bit destination select in bits 3 to 0 and reads zero above.
// - A source shows in a destination's decode register only when its routing selects that destination.
// - Each decode bit is the OR of every source mapped onto that bit.
// - Each of the eight destinations paces its pulses with its own 32-bit down-counter.
// - A write to a destination's pacing count loads its counter and starts it counting down at once.
// - Once an armed destination's counter is zero, one pulse fires as soon as any routed status bit is or becomes set.
`ifndef IDP_DEFS_VH
`define IDP_DEFS_VH

`define IDP_NUM_DEST      8
`define IDP_DEST_BITS     3
`define IDP_SRC_BITS      32
`define IDP_ADDR_BITS     8
`define IDP_ROUTE_W       4
// Register byte addresses
`define IDP_ADDR_ROUTE    8'h00
`define IDP_ADDR_DECODE   8'h20
`define IDP_ADDR_PACE     8'h40
`define IDP_ADDR_STATE    8'h60
// Field positions
`define IDP_ROUTE_MSB     3
`define IDP_RESET_BIT     16
// Reset values
`define IDP_ROUTE_RST     4'h0
`define IDP_COUNT_RST     32'h00000000
`define IDP_ZERO32        32'h00000000

`endif

/* verilog/idp_pacer.v */
// One destination's pacing counter and single pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "idp_defs.vh"

module idp_pacer (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // Software load
  input  wire        load,
  input  wire [31:0] loadValue,
  // Status of this destination
  input  wire        anyStatus,
  // Results
  output reg  [31:0] count,
  output reg         armed,
  output reg         irqPulse
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ARM  = 2'b10;

  reg [1:0] state;

  // Counter load, count down, single pulse
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count    <= `IDP_COUNT_RST;
      state    <= ST_IDLE;
      armed    <= 1'b0;
      irqPulse <= 1'b0;
    end else begin
      irqPulse <= 1'b0;
      if (load) begin
        count <= loadValue;
        state <= ST_ARM;
        armed <= 1'b1;
      end else begin
        case (state)
          ST_ARM: begin
            if (count != `IDP_ZERO32) begin
              count <= count - 32'h00000001;
            end else if (anyStatus) begin
              irqPulse <= 1'b1;
              state    <= ST_IDLE;
              armed    <= 1'b0;
            end
          end
          ST_IDLE: begin
            state <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
            armed <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // idp_pacer

`default_nettype wire

/* test/idp_cpu_model.sv */
// CPU side model counting destination 0 pulses
`timescale 1ns/1ps
`default_nettype none
module idp_cpu_model(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  irq,
  output logic      [31:0] hits);
  // Count pulses of destination 0
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n) hits <= 32'h0;
    else if (irq[0]) hits <= hits + 32'h1;
endmodule // idp_cpu_model
`default_nettype wire

/* test/idp_checker_assertions.sv */
// Port checker for decode and pacing
`timescale 1ns/1ps
`default_nettype none
module idp_checker(
  input wire logic ref_clk, arst_n, regWr, regRd, resetEvent,
  input wire logic [7:0] regAddr, physical_irq_destination,
  input wire logic [31:0] regWrData, regRdData, condition_status_bits,
  input wire logic [23:0] otherRouteSel);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Pace write, routed status and pulse of destination 0
  wire logic w = regWr && regAddr == 8'h40;
  wire logic s = condition_status_bits[0] && otherRouteSel[2:0] == 3'h0 && !w;
  wire logic p = physical_irq_destination[0];
  route_rd_a: assert property ($past(regRd) && $past(regAddr) == 8'h00
    |-> regRdData[31:4] == 28'h0) else $error("route");
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0) else $error("idle");
  no_src_a: assert property ((condition_status_bits == 32'h0 && !resetEvent)[*3]
    |-> physical_irq_destination == 8'h00) else $error("src");
  pace_hold_a: assert property (w && regWrData == 32'h5 |=> !p[*5]) else $error("hold");
  pace_run_a: assert property (w && regWrData == 32'h3 ##1 s[*4] |-> ##[1:2] p) else $error("run");
  zero_go_a: assert property (w && regWrData == 32'h0 ##1 s[*2] |-> ##[0:1] p) else $error("zero");
  pulse_one_a: assert property (p && !w |=> !p[*2]) else $error("once");
endmodule // idp_checker
`default_nettype wire

/* test/idp_decode_pacing_tb.sv */
// Bench for decode and pacing
`timescale 1ns/1ps
`default_nettype none
module idp_decode_pacing_tb;
  logic ref_clk = 0, arst_n = 0, regWr = 0, regRd = 0, resetEvent = 0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, condition_status_bits = 32'h0;
  logic [31:0] pv[3] = '{32'h5, 32'h0, 32'h3};
  logic [23:0] otherRouteSel = 24'h0;
  logic [3:0] rt = 4'h0;
  wire logic [31:0] regRdData, hits;
  wire logic [7:0] irq;
  int fail_count = 0, n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  idp_decode_pacing dut(.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .condition_status_bits(condition_status_bits), .otherRouteSel(otherRouteSel),
    .resetEvent(resetEvent), .physical_irq_destination(irq));
  idp_cpu_model cpu(.ref_clk(ref_clk), .arst_n(arst_n), .irq(irq), .hits(hits));
  task chk(string n, logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin fail_count++; $display("[ERR] %s exp %h seen %h", n, e, s); end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk) begin regWr <= 1; regAddr <= a; regWrData <= d; end
    @(posedge ref_clk) regWr <= 0;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk) begin regRd <= 1; regAddr <= a; end
    @(posedge ref_clk) regRd <= 0;
    #1 chk("reg", regRdData, e);
  endtask
  // Expected decode word of one destination
  function logic [31:0] dec(int d);
    dec = 32'h0;
    for (int b = 0; b < 32; b++)
      dec[b] = condition_status_bits[b] && otherRouteSel[3*(b%8)+:3] == d[2:0];
    dec[16] |= resetEvent && rt == d[3:0];
  endfunction
  task print_verdict;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin #200000 fail_count++; print_verdict; end
  initial begin
    void'($urandom(32'h6eb96031));
    repeat (4) @(posedge ref_clk);
    arst_n <= 1;
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'hF);
    for (int i = 0; i < 24; i++) begin
      rt = 4'($urandom % 8);
      wr(8'h00, {28'h0, rt});
      condition_status_bits <= $urandom;
      otherRouteSel <= 24'($urandom);
      resetEvent <= 1'($urandom);
      repeat (3) @(posedge ref_clk);
      rd(8'(32 + 4 * (i % 8)), dec(i % 8));
    end
    condition_status_bits <= 32'h1;
    otherRouteSel <= 24'h0;
    resetEvent <= 0;
    for (int k = 0; k < 3; k++) begin
      wr(8'h40, pv[k]);
      repeat (30) @(posedge ref_clk);
      chk("pulses", hits, k + 1);
    end
    // Live counter readback, armed state before and after the pulse
    wr(8'h40, 32'h64);
    rd(8'h40, 32'h63);
    rd(8'h60, 32'h1);
    repeat (120) @(posedge ref_clk);
    chk("pulses", hits, 32'h4);
    rd(8'h60, 32'h0);
    rd(8'h40, 32'h0);
    print_verdict;
  end
endmodule // idp_decode_pacing_tb
bind idp_decode_pacing idp_checker chk_i(.*);
`default_nettype wire
